// [mirror_trunk_filter.v]
// Mirror, trunk and static address policy for a 26-port switch forwarding path
`default_nettype none
`include "mirror_trunk_regs.vh"

module mirror_trunk_filter (
    input wire mclk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [25:0] link_up,
    input wire lkp_valid,
    input wire [4:0] lkp_src_port,
    input wire [47:0] lkp_src_mac,
    input wire [47:0] lkp_dst_mac,
    input wire [11:0] lkp_vlan,
    input wire [25:0] lkp_dst_mask,
    input wire mon_busy,
    output reg res_valid,
    output reg [25:0] res_fwd_mask,
    output reg res_drop,
    output reg res_learn,
    output reg [25:0] res_mon_mask,
    output reg res_mirror_drop
);

// ----------------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------------

// Member mask of a trunk from its count and base port, zero when not allowed
function [25:0] tk_members;
    input [3:0] cnt;
    input [4:0] base;
    reg [4:0] sa;
    reg [4:0] sb;
    begin
        sa = base - 5'd1;
        sb = base + 5'd11;
        tk_members = 26'h000_0000;
        case (cnt)
            4'd2: begin
                if (base >= 5'd1 && base <= 5'd12) begin
                    tk_members = (26'h000_0001 << sa) | (26'h000_0001 << sb);
                end else if (base == 5'd25) begin
                    tk_members = 26'h300_0000;
                end
            end
            4'd4: begin
                if (base[0] && base <= 5'd11) begin
                    tk_members = (26'h000_0003 << sa) | (26'h000_0003 << sb);
                end
            end
            4'd8: begin
                if (base == 5'd1 || base == 5'd5 || base == 5'd9) begin
                    tk_members = (26'h000_000F << sa) | (26'h000_000F << sb);
                end
            end
            default: tk_members = 26'h000_0000;
        endcase
    end
endfunction

// One-hot port number, zero outside 1..26
function [25:0] port_oh;
    input [4:0] p;
    begin
        if (p >= 5'd1 && p <= 5'd26) begin
            port_oh = 26'h000_0001 << (p - 5'd1);
        end else begin
            port_oh = 26'h000_0000;
        end
    end
endfunction

// Pick the hash-selected member among the live ones
function [25:0] pick;
    input [25:0] live;
    input [2:0] h;
    reg [4:0] c;
    reg [4:0] k;
    integer i;
    begin
        pick = 26'h000_0000;
        c = 5'd0;
        for (i = 0; i < `NPORT; i = i + 1) begin
            c = c + {4'd0, live[i]};
        end
        k = (c == 5'd0) ? 5'd0 : ({2'b00, h} % c);
        c = 5'd0;
        for (i = 0; i < `NPORT; i = i + 1) begin
            if (live[i]) begin
                if (c == k) begin
                    pick[i] = 1'b1;
                end
                c = c + 5'd1;
            end
        end
    end
endfunction

// ----------------------------------------------------------------------------
// Reset release and link synchroniser
// ----------------------------------------------------------------------------

reg [1:0] rst_sync_q;
wire rst_n = rst_sync_q[1];
reg [25:0] link_meta_q;
reg [25:0] link_q;

// Two-stage reset release
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        rst_sync_q <= 2'b00;
    end else begin
        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
end

// Link pins pass two flops
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        link_meta_q <= 26'h000_0000;
        link_q <= 26'h000_0000;
    end else begin
        link_meta_q <= link_up;
        link_q <= link_meta_q;
    end
end

// ----------------------------------------------------------------------------
// Configuration state
// ----------------------------------------------------------------------------

reg mir_en_q;
reg [4:0] mon_port_q;
reg [25:0] mir_rx_q;
reg [25:0] mir_tx_q;
reg [25:0] stp_blk_q;
reg tk_rej_q;
reg mir_rej_q;
reg [3:0] tk_v_q;
reg [3:0] tk_cnt_q [0:3];
reg [4:0] tk_base_q [0:3];
reg [25:0] tk_mask_q [0:3];
reg [3:0] uc_v_q;
reg [47:0] uc_mac_q [0:3];
reg [4:0] uc_port_q [0:3];
reg [3:0] mc_v_q;
reg [47:0] mc_mac_q [0:3];
reg [11:0] mc_vlan_q [0:3];
reg [25:0] mc_ports_q [0:3];

// Address decode
wire sel_tk = reg_addr[7:4] == `R_TRUNK_BASE;
wire sel_tm = reg_addr[7:4] == `R_TRUNK_MASK;
wire sel_uc = reg_addr[7:5] == `R_UC_BASE;
wire sel_mc = reg_addr >= `R_MC_FIRST && reg_addr <= `R_MC_LAST;
wire [7:0] mc_off = reg_addr - `R_MC_FIRST;
wire [1:0] tk_i = reg_addr[3:2];
wire [1:0] uc_i = reg_addr[4:3];
wire [1:0] mc_i = mc_off[5:4];
wire [1:0] mc_w = mc_off[3:2];

// Union of trunk members, optionally leaving one trunk out
reg [25:0] tk_all;
reg [25:0] tk_others;
integer t;
always @* begin
    tk_all = 26'h000_0000;
    tk_others = 26'h000_0000;
    for (t = 0; t < `NTRUNK; t = t + 1) begin
        if (tk_v_q[t]) begin
            tk_all = tk_all | tk_mask_q[t];
            if (t[1:0] != tk_i) begin
                tk_others = tk_others | tk_mask_q[t];
            end
        end
    end
end

// Candidate trunk and mirror settings checked before they are stored
wire [25:0] tk_new = tk_members(reg_wdata[`F_TK_CNT_HI:0], reg_wdata[`F_TK_BASE_HI:`F_TK_BASE_LO]);
wire [25:0] mon_oh = port_oh(mon_port_q);
wire [25:0] mir_set = mir_rx_q | mir_tx_q | mon_oh;
wire tk_bad = reg_wdata[`F_VALID] && (tk_new == 26'h000_0000 || (tk_new & tk_others) != 26'h000_0000
    || (tk_new & mir_set) != 26'h000_0000);
wire [25:0] mon_new = port_oh(reg_wdata[`F_MON_HI:`F_MON_LO]);
wire mir_bad = (reg_addr == `R_MIR_CTRL && (mon_new & tk_all) != 26'h000_0000)
    || ((reg_addr == `R_MIR_RX || reg_addr == `R_MIR_TX) && (reg_wdata[25:0] & tk_all) != 26'h000_0000);

// Register writes; static entries have no aging path at all
integer j;
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        mir_en_q <= 1'b0;
        mon_port_q <= 5'd0;
        mir_rx_q <= 26'h000_0000;
        mir_tx_q <= 26'h000_0000;
        stp_blk_q <= 26'h000_0000;
        tk_rej_q <= 1'b0;
        mir_rej_q <= 1'b0;
        tk_v_q <= 4'h0;
        uc_v_q <= 4'h0;
        mc_v_q <= 4'h0;
        for (j = 0; j < 4; j = j + 1) begin
            tk_cnt_q[j] <= 4'h0;
            tk_base_q[j] <= 5'd0;
            tk_mask_q[j] <= 26'h000_0000;
            uc_mac_q[j] <= 48'h0000_0000_0000;
            uc_port_q[j] <= 5'd0;
            mc_mac_q[j] <= 48'h0000_0000_0000;
            mc_vlan_q[j] <= 12'h000;
            mc_ports_q[j] <= 26'h000_0000;
        end
    end else if (reg_wr) begin
        if (reg_addr == `R_MIR_CTRL || reg_addr == `R_MIR_RX || reg_addr == `R_MIR_TX) begin
            mir_rej_q <= mir_bad;
            if (!mir_bad) begin
                if (reg_addr == `R_MIR_CTRL) begin
                    mir_en_q <= reg_wdata[`F_MIR_EN];
                    mon_port_q <= reg_wdata[`F_MON_HI:`F_MON_LO];
                end else if (reg_addr == `R_MIR_RX) begin
                    mir_rx_q <= reg_wdata[25:0];
                end else begin
                    mir_tx_q <= reg_wdata[25:0];
                end
            end
        end
        if (reg_addr == `R_STP_BLOCK) begin
            stp_blk_q <= reg_wdata[25:0];
        end
        if (sel_tk) begin
            tk_rej_q <= tk_bad;
            if (!tk_bad) begin
                tk_v_q[tk_i] <= reg_wdata[`F_VALID];
                tk_cnt_q[tk_i] <= reg_wdata[`F_TK_CNT_HI:0];
                tk_base_q[tk_i] <= reg_wdata[`F_TK_BASE_HI:`F_TK_BASE_LO];
                tk_mask_q[tk_i] <= reg_wdata[`F_VALID] ? tk_new : 26'h000_0000;
            end
        end
        if (sel_uc) begin
            if (!reg_addr[2]) begin
                uc_mac_q[uc_i][31:0] <= reg_wdata;
            end else begin
                uc_mac_q[uc_i][47:32] <= reg_wdata[15:0];
                uc_port_q[uc_i] <= reg_wdata[`F_UC_PORT_HI:`F_UC_PORT_LO];
                uc_v_q[uc_i] <= reg_wdata[`F_VALID];
            end
        end
        if (sel_mc) begin
            if (mc_w == 2'd0) begin
                mc_mac_q[mc_i][31:0] <= reg_wdata;
            end else if (mc_w == 2'd1) begin
                mc_mac_q[mc_i][47:32] <= reg_wdata[15:0];
                mc_vlan_q[mc_i] <= reg_wdata[`F_MC_VLAN_HI:`F_MC_VLAN_LO];
                mc_v_q[mc_i] <= reg_wdata[`F_VALID];
            end else if (mc_w == 2'd2) begin
                mc_ports_q[mc_i] <= reg_wdata[25:0];
            end
        end
    end
end

// Read mux; data stands only in the cycle after the strobe
reg [31:0] rd_val;
always @* begin
    rd_val = `RST_ZERO;
    if (reg_addr == `R_MIR_CTRL) begin
        rd_val = {19'd0, mon_port_q, 7'd0, mir_en_q};
    end else if (reg_addr == `R_MIR_RX) begin
        rd_val = {6'd0, mir_rx_q};
    end else if (reg_addr == `R_MIR_TX) begin
        rd_val = {6'd0, mir_tx_q};
    end else if (reg_addr == `R_STATUS) begin
        rd_val = {30'd0, mir_rej_q, tk_rej_q};
    end else if (reg_addr == `R_STP_BLOCK) begin
        rd_val = {6'd0, stp_blk_q};
    end else if (reg_addr == `R_LINK) begin
        rd_val = {6'd0, link_q};
    end else if (sel_tk) begin
        rd_val = {tk_v_q[tk_i], 18'd0, tk_base_q[tk_i], 4'd0, tk_cnt_q[tk_i]};
    end else if (sel_tm) begin
        rd_val = {6'd0, tk_mask_q[tk_i]};
    end else if (sel_uc) begin
        rd_val = reg_addr[2] ? {uc_v_q[uc_i], 10'd0, uc_port_q[uc_i], uc_mac_q[uc_i][47:32]}
            : uc_mac_q[uc_i][31:0];
    end else if (sel_mc) begin
        if (mc_w == 2'd0) begin
            rd_val = mc_mac_q[mc_i][31:0];
        end else if (mc_w == 2'd1) begin
            rd_val = {mc_v_q[mc_i], 3'd0, mc_vlan_q[mc_i], mc_mac_q[mc_i][47:32]};
        end else if (mc_w == 2'd2) begin
            rd_val = {6'd0, mc_ports_q[mc_i]};
        end
    end
end

// ----------------------------------------------------------------------------
// Frame lookup path
// ----------------------------------------------------------------------------

reg [25:0] blk_eff;
reg [25:0] fwd;
reg [25:0] pool;
reg [25:0] src_lport;
reg [25:0] mc_set;
reg mc_hit;
reg uc_bad;
reg mir_hit;
wire [25:0] src_oh = port_oh(lkp_src_port);
wire [2:0] hash = lkp_src_mac[2:0] ^ lkp_src_mac[10:8] ^ lkp_dst_mac[2:0] ^ lkp_dst_mac[10:8];
integer k;
always @* begin
    blk_eff = stp_blk_q;
    src_lport = src_oh;
    uc_bad = 1'b0;
    mc_hit = 1'b0;
    mc_set = 26'h000_0000;
    // Static unicast and multicast matches on full keys
    for (k = 0; k < `NUC; k = k + 1) begin
        if (uc_v_q[k] && uc_mac_q[k] == lkp_src_mac && uc_port_q[k] != lkp_src_port) begin
            uc_bad = 1'b1;
        end
    end
    for (k = 0; k < `NMC; k = k + 1) begin
        if (mc_v_q[k] && mc_mac_q[k] == lkp_dst_mac && mc_vlan_q[k] == lkp_vlan) begin
            mc_hit = 1'b1;
            mc_set = mc_set | mc_ports_q[k];
        end
    end
    fwd = mc_hit ? mc_set : lkp_dst_mask;
    // Trunks act as one logical port for VLAN, STP and source exclusion
    for (k = 0; k < `NTRUNK; k = k + 1) begin
        if (tk_v_q[k] && (stp_blk_q & tk_mask_q[k]) != 26'h000_0000) begin
            blk_eff = blk_eff | tk_mask_q[k];
        end
        if (tk_v_q[k] && !mc_hit && (lkp_dst_mask & tk_mask_q[k]) != 26'h000_0000) begin
            fwd = fwd | tk_mask_q[k];
        end
        if (tk_v_q[k] && (src_oh & tk_mask_q[k]) != 26'h000_0000) begin
            src_lport = src_lport | tk_mask_q[k];
        end
    end
    fwd = fwd & ~src_lport & ~blk_eff;
    // One live member per trunk, chosen by hash
    for (k = 0; k < `NTRUNK; k = k + 1) begin
        pool = (mc_hit ? (fwd & tk_mask_q[k]) : tk_mask_q[k]) & link_q & ~blk_eff;
        if (tk_v_q[k] && (fwd & tk_mask_q[k]) != 26'h000_0000) begin
            fwd = (fwd & ~tk_mask_q[k]) | pick(pool, hash);
        end
    end
    if (uc_bad) begin
        fwd = 26'h000_0000;
    end
    // Mirror on received source or on any transmit port in the result
    mir_hit = mir_en_q && mon_oh != 26'h000_0000 && ((mir_rx_q & src_oh) != 26'h000_0000
        || (mir_tx_q & fwd) != 26'h000_0000);
end

// Result and read data registers
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= `RST_ZERO;
        res_valid <= 1'b0;
        res_fwd_mask <= 26'h000_0000;
        res_drop <= 1'b0;
        res_learn <= 1'b0;
        res_mon_mask <= 26'h000_0000;
        res_mirror_drop <= 1'b0;
    end else begin
        reg_rdata <= reg_rd ? rd_val : `RST_ZERO;
        res_valid <= lkp_valid;
        res_fwd_mask <= lkp_valid ? fwd : 26'h000_0000;
        res_drop <= lkp_valid && uc_bad;
        res_learn <= lkp_valid && !uc_bad;
        res_mon_mask <= (lkp_valid && mir_hit && !mon_busy) ? mon_oh : 26'h000_0000;
        res_mirror_drop <= lkp_valid && mir_hit && mon_busy;
    end
end

endmodule
`default_nettype wire

// [mirror_trunk_filter_chk.sv]
// Concurrent checks on the ports of the mirror, trunk and static address block
`default_nettype none
module mirror_trunk_filter_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic lkp_valid,
    input wire logic mon_busy,
    input wire logic res_valid,
    input wire logic [25:0] res_fwd_mask,
    input wire logic res_drop,
    input wire logic res_learn,
    input wire logic [25:0] res_mon_mask,
    input wire logic res_mirror_drop
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------------------
    // Lookup answer and register read timing
    // ----------------------------------------------------------------------------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    res_pulse_a: assert property (lkp_valid ##1 !lkp_valid |-> res_valid ##1 !res_valid)
        else $error("lookup answer not one pulse");
    res_none_a: assert property (!lkp_valid |=> !res_valid)
        else $error("answer without lookup");
    idle_zero_a: assert property (!res_valid |-> res_fwd_mask == 0 && res_mon_mask == 0
        && !res_drop && !res_mirror_drop)
        else $error("result fields set while idle");
    drop_excl_a: assert property (res_drop |-> res_valid && res_fwd_mask == 0 && !res_learn)
        else $error("dropped frame still forwarded or learned");
    learn_flag_a: assert property (res_valid |-> res_learn != res_drop)
        else $error("learn flag does not oppose drop");
    mon_onehot_a: assert property (res_mon_mask != 0 |-> $onehot(res_mon_mask) && !res_mirror_drop)
        else $error("monitor copy not to one port");
    busy_drop_a: assert property (res_mirror_drop |-> $past(mon_busy) && res_valid)
        else $error("copy lost while monitor was free");
    mon_free_a: assert property (res_mon_mask != 0 |-> !$past(mon_busy))
        else $error("copy sent to a busy monitor");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside its cycle");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h6C |=> reg_rdata == 0)
        else $error("unmapped read not zero");
endmodule
bind mirror_trunk_filter mirror_trunk_filter_chk u_mirror_trunk_filter_chk (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lkp_valid(lkp_valid), .mon_busy(mon_busy),
    .res_valid(res_valid), .res_fwd_mask(res_fwd_mask), .res_drop(res_drop), .res_learn(res_learn),
    .res_mon_mask(res_mon_mask), .res_mirror_drop(res_mirror_drop));
`default_nettype wire

// [mirror_trunk_regs.vh]
// Register offsets, field positions, reset values and table sizes of the forwarding policy block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef MIRROR_TRUNK_REGS_VH
`define MIRROR_TRUNK_REGS_VH

`define R_MIR_CTRL 8'h00
`define R_MIR_RX 8'h04
`define R_MIR_TX 8'h08
`define R_STATUS 8'h0C
`define R_STP_BLOCK 8'h10
`define R_LINK 8'h14
`define R_TRUNK_BASE 4'h2
`define R_TRUNK_MASK 4'h3
`define R_UC_BASE 3'b010
`define R_MC_FIRST 8'h60
`define R_MC_LAST 8'h9C
`define F_MIR_EN 0
`define F_MON_LO 8
`define F_MON_HI 12
`define F_VALID 31
`define F_TK_CNT_HI 3
`define F_TK_BASE_LO 8
`define F_TK_BASE_HI 12
`define F_UC_PORT_LO 16
`define F_UC_PORT_HI 20
`define F_MC_VLAN_LO 16
`define F_MC_VLAN_HI 27
`define NPORT 26
`define NTRUNK 4
`define NUC 4
`define NMC 4
`define RST_ZERO 32'h0000_0000

`endif

// [port_side_model.sv]
// Model of the port side: cable state per port and monitor port backpressure
`default_nettype none
module port_side_model #(
    parameter int UP_DELAY = 4
) (
    input wire logic mclk,
    input wire logic [25:0] cabled,
    input wire logic busy_req,
    output logic [25:0] link_up,
    output logic mon_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [25:0] prev_q = 26'h000_0000;
    int cnt_q = 0;
    logic [25:0] up_q = 26'h000_0000;
    // Link state leaves through one driver
    assign link_up = up_q;
    // Link training: new cables come up after a quiet spell, pulled cables drop at once
    always @(posedge mclk) begin
        prev_q <= cabled;
        cnt_q <= ((cabled & ~prev_q) != 0) ? 0 : cnt_q + 1;
        up_q <= (cnt_q >= UP_DELAY) ? cabled : (up_q & cabled);
    end
    // Monitor backpressure is a plain level
    assign mon_busy = busy_req;
endmodule
`default_nettype wire

// [switch_mirror_trunk_static_filter_tb_top.sv]
// Self-checking bench for the mirror, trunk and static address policy block
`default_nettype none
`include "mirror_trunk_regs.vh"
module switch_mirror_trunk_static_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, lkp_valid = 0, busy_req = 0;
    logic mon_busy, res_valid, res_drop, res_learn, res_mirror_drop;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [31:0] rnd = 32'h0001_6B95;
    logic [4:0] lkp_src_port = 0;
    logic [47:0] lkp_src_mac = 0, lkp_dst_mac = 0;
    logic [11:0] lkp_vlan = 0;
    logic [25:0] lkp_dst_mask = 0, cabled = 26'h0FF_FFFF, link_up, res_fwd_mask, res_mon_mask;
    int miscompares = 0, n_compared = 0, cyc = 0;
    // ----------------------------------------------------------------------------
    // Clock, design and port side
    // ----------------------------------------------------------------------------
    initial forever #50 mclk = ~mclk;
    mirror_trunk_filter u_mirror_trunk_filter (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
        .lkp_valid(lkp_valid), .lkp_src_port(lkp_src_port), .lkp_src_mac(lkp_src_mac),
        .lkp_dst_mac(lkp_dst_mac), .lkp_vlan(lkp_vlan), .lkp_dst_mask(lkp_dst_mask), .mon_busy(mon_busy),
        .res_valid(res_valid), .res_fwd_mask(res_fwd_mask), .res_drop(res_drop), .res_learn(res_learn),
        .res_mon_mask(res_mon_mask), .res_mirror_drop(res_mirror_drop));
    port_side_model u_port_side_model (.mclk(mclk), .cabled(cabled), .busy_req(busy_req),
        .link_up(link_up), .mon_busy(mon_busy));
    // ----------------------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [25:0] pb(input int p);
        return 26'h000_0001 << (p - 1);
    endfunction
    function automatic bit legal(input int c, input int n);
        return (c == 2 && (n <= 12 || n == 25)) || (c == 4 && n % 2 == 1 && n <= 11)
            || (c == 8 && n % 4 == 1 && n <= 9);
    endfunction
    function automatic logic [25:0] tmask(input int c, input int n);
        logic [25:0] m;
        m = 0;
        if (n == 25) m = 26'h300_0000;
        else for (int i = 0; i < c / 2; i++) m = m | pb(n + i) | pb(n + 12 + i);
        return m;
    endfunction
    function automatic int hsel(input logic [47:0] s, input logic [47:0] d);
        logic [2:0] h;
        h = s[2:0] ^ s[10:8] ^ d[2:0] ^ d[10:8];
        return int'(h[0]);
    endfunction
    // ----------------------------------------------------------------------------
    // Bus and lookup tasks
    // ----------------------------------------------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic lk(input int s, input logic [47:0] sm, input logic [47:0] dm, input logic [11:0] vl,
        input logic [25:0] m, input logic b, input logic [25:0] ef, input logic ed, input logic [25:0] em,
        input logic emd);
        @(posedge mclk);
        lkp_valid <= 1'b1;
        lkp_src_port <= 5'(s);
        lkp_src_mac <= sm;
        lkp_dst_mac <= dm;
        lkp_vlan <= vl;
        lkp_dst_mask <= m;
        busy_req <= b;
        @(posedge mclk);
        lkp_valid <= 1'b0;
        #1 chk({res_valid, res_drop, res_learn, res_mirror_drop}, {3'b1_0_0 | {1'b0, ed, !ed}, emd});
        chk(res_fwd_mask, ef);
        chk(res_mon_mask, em);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    // ----------------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------------
    initial begin
        int s;
        logic b;
        logic w;
        logic [25:0] m, f, e;
        static logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h30, 8'h40};
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (ra[i]) rd(ra[i], 32'h0000_0000);
        rd(8'h14, 32'h00FF_FFFF);
        $display("test reset values done");
        for (int c = 2; c <= 8; c++) for (int n = 1; n <= 25; n++) begin
            wr(8'h20, 32'h8000_0000 | (n << 8) | c);
            rd(8'h0C, {31'h0, !legal(c, n)});
            rd(8'h30, legal(c, n) ? tmask(c, n) : 26'h0);
            wr(8'h20, 32'h0000_0000);
        end
        wr(8'h20, 32'h8000_0102);
        wr(8'h24, 32'h8000_0104);
        rd(8'h34, 32'h0000_0000);
        wr(8'h04, 32'h0000_0001);
        rd(8'h0C, 32'h0000_0003);
        rd(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0D01);
        rd(8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_0010);
        wr(8'h24, 32'h8000_0502);
        rd(8'h0C, 32'h0000_0001);
        wr(8'h20, 32'h0000_0000);
        $display("test trunk groups done");
        wr(8'h00, 32'h0000_1401);
        wr(8'h04, 32'h0000_0004);
        wr(8'h08, 32'h0000_0040);
        for (int i = 0; i < 200; i++) begin
            rnd = lfsr(rnd);
            s = 1 + rnd[31:8] % 24;
            m = rnd[25:0];
            b = rnd[7] & rnd[3];
            f = m & ~pb(s);
            w = (s == 3) || f[6];
            e = (w && !b) ? pb(20) : 26'h000_0000;
            lk(s, {16'h0, rnd}, {rnd, 16'h0}, rnd[11:0], m, b, f, 0, e, w && b);
        end
        wr(8'h00, 32'h0000_1400);
        lk(3, 48'h1, 48'h2, 12'h001, pb(4) | pb(7), 0, pb(4) | pb(7), 0, 0, 0);
        $display("test mirror done");
        wr(8'h40, 32'h2C3D_4E5F);
        wr(8'h44, 32'h8005_0A1B);
        lk(5, 48'h0A1B_2C3D_4E5F, 48'h2, 12'h001, pb(2), 0, pb(2), 0, 0, 0);
        lk(6, 48'h0A1B_2C3D_4E5F, 48'h2, 12'h001, pb(2), 0, 0, 1, 0, 0);
        lk(6, 48'h8A1B_2C3D_4E5F, 48'h2, 12'h001, pb(2), 0, pb(2), 0, 0, 0);
        wr(8'h60, 32'h5E00_0001);
        wr(8'h64, 32'h800A_0100);
        wr(8'h68, 32'h0000_0102);
        rd(8'h6C, 32'h0000_0000);
        lk(1, 48'h1, 48'h0100_5E00_0001, 12'h00A, 26'h3FF_FFFF, 0, 26'h000_0102, 0, 0, 0);
        lk(1, 48'h1, 48'h0100_5E00_0001, 12'h00B, 26'h000_0006, 0, 26'h000_0006, 0, 0, 0);
        $display("test static entries done");
        wr(8'h20, 32'h8000_1902);
        cabled <= 26'h3FF_FFFF;
        repeat (12) @(posedge mclk);
        rd(8'h14, 32'h03FF_FFFF);
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            if (i == 16) begin
                cabled <= 26'h2FF_FFFF;
                repeat (4) @(posedge mclk);
            end
            m = pb(25 + rnd[9]);
            f = pb(i < 16 ? 25 + hsel({16'h0, rnd}, {rnd, 16'h0}) : 26);
            lk(1, {16'h0, rnd}, {rnd, 16'h0}, 12'h001, m, 0, f, 0, 0, 0);
        end
        wr(8'h10, 32'h0200_0000);
        lk(1, 48'h1, 48'h2, 12'h001, pb(25), 0, 0, 0, 0, 0);
        $display("test trunk traffic done");
        end_sim();
    end
endmodule
`default_nettype wire
